// >>> core/msf_pkg.sv
// Constants and types shared by the measurement smoothing filter
package msf_pkg;

    // Data path widths
    localparam int SAMPLE_W   = 24;        // Width of one signed distance sample
    localparam int AVG_AW     = 12;        // Address width of the sliding window store
    localparam int AVG_FILL_W = 13;        // Window fill counter, holds up to 4096
    localparam int SUM_W      = 36;        // Running sum, sample plus log2 of 4096
    localparam int REC_N_W    = 15;        // Recursive weight, 1 to 32767
    localparam int NUM_W      = 40;        // Recursive numerator width
    localparam int MED_MAX    = 9;         // Deepest median window
    localparam int MED_CNT_W  = 4;         // Median counters and ranks
    localparam int DIV_CNT_W  = 6;         // Divider step counter
    localparam int CFG_W      = 25;        // Width of the packed configuration

    // Limits and fixed counts
    localparam logic [3:0]            AVG_MAX_LOG2 = 4'hC;     // Largest window is 4096
    localparam logic [AVG_FILL_W-1:0] AVG_FILL_MAX = 13'h1000; // Fill saturates at 4096
    localparam logic [DIV_CNT_W-1:0]  DIV_STEPS    = 6'h28;    // One step per numerator bit
    localparam logic [REC_N_W-1:0]    REC_N_MIN    = 15'h0001; // Weight used when zero is set

    // Legal median widths
    localparam logic [MED_CNT_W-1:0] MED_W3 = 4'h3;
    localparam logic [MED_CNT_W-1:0] MED_W5 = 4'h5;
    localparam logic [MED_CNT_W-1:0] MED_W7 = 4'h7;
    localparam logic [MED_CNT_W-1:0] MED_W9 = 4'h9;

    // Filter setting of a channel
    typedef enum logic [1:0] {
        MODE_NONE  = 2'h0,
        MODE_SLIDE = 2'h1,
        MODE_REC   = 2'h2,
        MODE_MED   = 2'h3
    } msf_mode_type;

    // Sequencer states, Gray along IDLE-LOAD-DIV-DONE-IDLE
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_DIV  = 2'b11,
        ST_DONE = 2'b10
    } msf_state_type;

endpackage

// >>> core/msf_sample_ram.sv
// Sample history store for the sliding average window
`timescale 1ns/1ps
module msf_sample_ram #(
    parameter int DATA_W = 24,
    parameter int ADDR_W = 12
) (
    // Clock
    input  wire logic              clk_sys,
    // Write side
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    // Read side
    input  wire logic              rd_en,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data
);

    logic [DATA_W-1:0] mem [2**ADDR_W];

    // No reset on purpose: stale words are never used before a write covers them
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read port
    always_ff @(posedge clk_sys) begin
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule // msf_sample_ram

// >>> core/msf_filter.sv
// Measurement smoothing filter: sliding average, recursive average, median
//
// Notes on behaviour
// R1: Sliding mode outputs mean of last N samples
// R2: Each sample enters window, oldest sample leaves
// R3: Sliding width only powers of two, max 4096
// R4: Recursive: (sample plus (N-1) times previous)/N
// R5: Median window re-sorted after every sample
// R6: Median output is middle of sorted window
// R7: Median width limited to 3, 5, 7, 9
// R8: Exactly one filter setting active per channel
// R9: Reset or reconfiguration clears history, reseeds recursion
`timescale 1ns/1ps
module msf_filter (
    // Clock and reset
    input  wire logic                           clk_sys,
    input  wire logic                           sys_rst,
    // Incoming samples
    input  wire logic [msf_pkg::SAMPLE_W-1:0]   raw_sample,
    input  wire logic                           sample_valid,
    output logic                                sample_ready,
    // Configuration
    input  wire logic [1:0]                     filter_mode,
    input  wire logic [3:0]                     avg_log2,
    input  wire logic [msf_pkg::REC_N_W-1:0]    rec_width,
    input  wire logic [msf_pkg::MED_CNT_W-1:0]  med_width,
    // Filtered result
    output logic [msf_pkg::SAMPLE_W-1:0]        filt_out,
    output logic                                filt_valid
);
    import msf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Widths above 4096 fall back to 4096
    function automatic logic [3:0] clamp_log2(input logic [3:0] k);
        clamp_log2 = (k > AVG_MAX_LOG2) ? AVG_MAX_LOG2 : k;
    endfunction

    // Unsupported median widths fall back to 3
    function automatic logic [MED_CNT_W-1:0] med_len(input logic [MED_CNT_W-1:0] w);
        case (w)
            MED_W5:  med_len = MED_W5;
            MED_W7:  med_len = MED_W7;
            MED_W9:  med_len = MED_W9;
            default: med_len = MED_W3;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    msf_state_type              state;
    msf_state_type              next_state;
    msf_mode_type               mode;
    logic [CFG_W-1:0]           cfg_now;
    logic [CFG_W-1:0]           cfg_prev;
    logic                       cfg_changed;
    logic                       take;
    logic signed [SAMPLE_W-1:0] smp;
    // Sliding average
    logic [3:0]                 avg_k;
    logic [AVG_FILL_W-1:0]      win_n;
    logic [AVG_AW-1:0]          wr_ptr;
    logic [AVG_AW-1:0]          old_addr;
    logic [AVG_FILL_W-1:0]      avg_fill;
    logic                       avg_full;
    logic [SAMPLE_W-1:0]        old_word;
    logic signed [SUM_W-1:0]    avg_sum;
    logic signed [SUM_W-1:0]    next_sum;
    logic signed [SUM_W-1:0]    sum_shift;
    logic                       avg_wr;
    // Recursive average
    logic signed [SAMPLE_W-1:0] rec_prev;
    logic                       rec_seeded;
    logic [REC_N_W-1:0]         rec_den;
    logic signed [NUM_W-1:0]    rec_num;
    logic [NUM_W-1:0]           num_mag;
    logic [NUM_W-1:0]           div_quo;
    logic [REC_N_W:0]           div_rem;
    logic [REC_N_W:0]           div_try;
    logic                       div_ge;
    logic                       div_neg;
    logic [DIV_CNT_W-1:0]       div_cnt;
    logic signed [SAMPLE_W-1:0] rec_result;
    // Median
    logic signed [SAMPLE_W-1:0] med_buf  [MED_MAX];
    logic [MED_CNT_W-1:0]       med_rank [MED_MAX];
    logic [MED_CNT_W-1:0]       med_fill;
    logic [MED_CNT_W-1:0]       med_weff;
    logic [MED_CNT_W-1:0]       med_mid;
    logic signed [SAMPLE_W-1:0] med_pick;
    // Output selection
    logic                       out_load;
    logic [SAMPLE_W-1:0]        next_out;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and sample acceptance

    // A changed setting is absorbed in IDLE before the next sample is taken
    assign mode         = msf_mode_type'(filter_mode);                     // R8
    assign cfg_now      = {filter_mode, avg_log2, rec_width, med_width};
    assign cfg_changed  = (cfg_now != cfg_prev);
    assign sample_ready = (state == ST_IDLE) && !cfg_changed;
    assign take         = sample_ready && sample_valid;

    // Sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: if (take) next_state = ST_LOAD;
            ST_LOAD: next_state = (mode == MODE_REC && rec_seeded) ? ST_DIV : ST_IDLE;
            ST_DIV:  if (div_cnt == DIV_CNT_W'(1)) next_state = ST_DONE;
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        state <= sys_rst ? ST_IDLE : next_state;
    end

    // Held copy of the accepted sample and of the settings in use
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            smp      <= '0;
            cfg_prev <= '0;
        end else begin
            if (take) smp <= raw_sample;
            if (state == ST_IDLE) cfg_prev <= cfg_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sliding average

    // Old sample is read while the new one is taken, written one cycle later
    assign avg_k     = clamp_log2(avg_log2);                               // R3
    assign win_n     = AVG_FILL_W'(1) << avg_k;                            // R3
    assign old_addr  = wr_ptr - win_n[AVG_AW-1:0];
    assign avg_full  = (avg_fill >= win_n);
    assign avg_wr    = (state == ST_LOAD) && (mode == MODE_SLIDE);
    assign next_sum  = avg_sum + SUM_W'(smp)
                       - (avg_full ? SUM_W'($signed(old_word)) : SUM_W'(0)); // R2
    assign sum_shift = next_sum >>> avg_k;                                 // R1

    msf_sample_ram #(
        .DATA_W (SAMPLE_W),
        .ADDR_W (AVG_AW)
    ) u_ram (
        .clk_sys (clk_sys),
        .wr_en   (avg_wr),
        .wr_addr (wr_ptr),
        .wr_data (smp),
        .rd_en   (take),
        .rd_addr (old_addr),
        .rd_data (old_word)
    );

    // Until the window fills, missing samples count as zero
    always_ff @(posedge clk_sys) begin
        if (sys_rst || (state == ST_IDLE && cfg_changed)) begin            // R9
            avg_sum  <= '0;
            avg_fill <= '0;
            wr_ptr   <= '0;
        end else if (avg_wr) begin
            avg_sum  <= next_sum;                                          // R1
            wr_ptr   <= wr_ptr + AVG_AW'(1);                               // R2
            if (avg_fill != AVG_FILL_MAX) avg_fill <= avg_fill + AVG_FILL_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Recursive average

    // Zero weight would divide by zero, so it acts as weight 1
    assign rec_den = (rec_width == '0) ? REC_N_MIN : rec_width;            // R4
    assign rec_num = NUM_W'(rec_prev * $signed({1'b0, rec_den - REC_N_MIN}))
                     + NUM_W'(smp);                                        // R4
    assign num_mag = rec_num[NUM_W-1] ? NUM_W'(-rec_num) : NUM_W'(rec_num);
    // Restoring division, one quotient bit per cycle
    assign div_try = {div_rem[REC_N_W-1:0], div_quo[NUM_W-1]};
    assign div_ge  = (div_try >= {1'b0, rec_den});
    // Quotient truncates toward zero
    assign rec_result = div_neg ? -$signed(div_quo[SAMPLE_W-1:0])
                                : $signed(div_quo[SAMPLE_W-1:0]);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            div_quo <= '0;
            div_rem <= '0;
            div_neg <= 1'b0;
            div_cnt <= '0;
        end else if (state == ST_LOAD) begin
            div_quo <= num_mag;
            div_rem <= '0;
            div_neg <= rec_num[NUM_W-1];
            div_cnt <= DIV_STEPS;
        end else if (state == ST_DIV) begin
            div_quo <= {div_quo[NUM_W-2:0], div_ge};                       // R4
            div_rem <= div_ge ? div_try - {1'b0, rec_den} : div_try;
            div_cnt <= div_cnt - DIV_CNT_W'(1);
        end
    end

    // First sample after reset or reconfiguration seeds the average
    always_ff @(posedge clk_sys) begin
        if (sys_rst || (state == ST_IDLE && cfg_changed)) begin            // R9
            rec_prev   <= '0;
            rec_seeded <= 1'b0;
        end else if (state == ST_LOAD && mode == MODE_REC && !rec_seeded) begin
            rec_prev   <= smp;                                             // R9
            rec_seeded <= 1'b1;
        end else if (state == ST_DONE) begin
            rec_prev   <= rec_result;                                      // R4
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Median

    // Window shrinks to the samples seen so far after a clear
    assign med_weff = (med_fill < med_len(med_width)) ? med_fill
                                                      : med_len(med_width); // R7
    assign med_mid  = (med_weff - MED_CNT_W'(1)) >> 1;                     // R6

    // History shift, newest at index 0
    genvar gi;
    generate
        for (gi = 0; gi < MED_MAX; gi++) begin : g_med
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    med_buf[gi] <= '0;
                end else if (take) begin
                    med_buf[gi] <= (gi == 0) ? raw_sample : med_buf[(gi == 0) ? 0 : gi - 1];
                end
            end

            // Rank is the sorted position; among ties the newer sample ranks lower
            always_comb begin
                med_rank[gi] = '0;
                for (int j = 0; j < MED_MAX; j++) begin
                    if (MED_CNT_W'(j) < med_weff && j != gi &&
                        (med_buf[j] < med_buf[gi] ||
                         (med_buf[j] == med_buf[gi] && j < gi))) begin
                        med_rank[gi] = med_rank[gi] + MED_CNT_W'(1);       // R5
                    end
                end
            end
        end
    endgenerate

    // Middle-ranked element of the current window
    always_comb begin
        med_pick = '0;
        for (int i = 0; i < MED_MAX; i++) begin
            if (MED_CNT_W'(i) < med_weff && med_rank[i] == med_mid) begin
                med_pick = med_buf[i];                                     // R6
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst || (state == ST_IDLE && cfg_changed)) begin            // R9
            med_fill <= '0;
        end else if (take && med_fill != MED_W9) begin
            med_fill <= med_fill + MED_CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output

    // One result for every accepted sample, chosen by the active setting
    assign out_load = (state == ST_DONE) ||
                      (state == ST_LOAD && !(mode == MODE_REC && rec_seeded));
    always_comb begin
        case (mode)                                                        // R8
            MODE_SLIDE: next_out = sum_shift[SAMPLE_W-1:0];
            MODE_REC:   next_out = (state == ST_DONE) ? rec_result : smp;
            MODE_MED:   next_out = med_pick;
            default:    next_out = smp;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            filt_out   <= '0;
            filt_valid <= 1'b0;
        end else begin
            filt_valid <= out_load;
            if (out_load) filt_out <= next_out;
        end
    end

endmodule // msf_filter

// >>> sim/msf_filter_checker.sv
// Port-level assertions for the measurement smoothing filter
`timescale 1ns/1ps
module msf_filter_checker (
    // Clock and reset
    input wire logic                          clk_sys,
    input wire logic                          sys_rst,
    // Sample stream
    input wire logic [msf_pkg::SAMPLE_W-1:0]  raw_sample,
    input wire logic                          sample_valid,
    input wire logic                          sample_ready,
    // Configuration
    input wire logic [1:0]                    filter_mode,
    input wire logic [3:0]                    avg_log2,
    input wire logic [msf_pkg::REC_N_W-1:0]   rec_width,
    input wire logic [msf_pkg::MED_CNT_W-1:0] med_width,
    // Result
    input wire logic [msf_pkg::SAMPLE_W-1:0]  filt_out,
    input wire logic                          filt_valid
);
    import msf_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    logic [SAMPLE_W-1:0] last_take;
    ////////////////////////////////////////
    // Last accepted sample, reference for the unity-weight cases
    always_ff @(posedge clk_sys) begin
        if (sample_valid && sample_ready) begin
            last_take <= raw_sample;
        end
    end
    ////////////////////////////////////////
    // Accepted sample, and the short-mode answer two edges on
    sequence s_take;
        sample_valid && sample_ready;
    endsequence
    sequence s_short_answer;
        ##2 filt_valid;
    endsequence
    property p_reset_clear;
        $fell(sys_rst) |-> filt_out == '0 && !filt_valid;
    endproperty
    property p_cfg_refuse;
        disable iff (sys_rst) !$past(sys_rst) && ({filter_mode, avg_log2, rec_width, med_width}
            != $past({filter_mode, avg_log2, rec_width, med_width})) |-> !sample_ready;
    endproperty
    property p_busy;
        disable iff (sys_rst) s_take |=> !sample_ready;
    endproperty
    property p_none_pass;
        disable iff (sys_rst) s_take ##0 (filter_mode == MODE_NONE)
            |-> s_short_answer ##0 (filt_out == $past(raw_sample, 2));
    endproperty
    property p_slide_answer;
        disable iff (sys_rst) s_take ##0 (filter_mode == MODE_SLIDE) |-> s_short_answer;
    endproperty
    property p_med_answer;
        disable iff (sys_rst) s_take ##0 (filter_mode == MODE_MED) |-> s_short_answer;
    endproperty
    property p_rec_answer;
        disable iff (sys_rst) s_take ##0 (filter_mode == MODE_REC)
            |-> s_short_answer or (##43 filt_valid);
    endproperty
    property p_passthru;
        disable iff (sys_rst) filt_valid && (filter_mode == MODE_NONE
            || (filter_mode == MODE_REC && rec_width <= 15'h0001)
            || (filter_mode == MODE_SLIDE && avg_log2 == 4'h0)) |-> filt_out == last_take;
    endproperty
    property p_pulse;
        disable iff (sys_rst) filt_valid |=> !filt_valid;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left output");
    a_cfg_refuse: assert property (p_cfg_refuse) else $error("ready on new config");
    a_busy: assert property (p_busy) else $error("ready while busy");
    a_none_pass: assert property (p_none_pass) else $error("bypass output wrong");
    a_slide_answer: assert property (p_slide_answer) else $error("no window result");
    a_med_answer: assert property (p_med_answer) else $error("no median result");
    a_rec_answer: assert property (p_rec_answer) else $error("recursive timing wrong");
    a_passthru: assert property (p_passthru) else $error("unity weight altered value");
    a_pulse: assert property (p_pulse) else $error("result flag too long");
endmodule // msf_filter_checker

bind msf_filter msf_filter_checker msf_filter_checker_inst (
    .clk_sys, .sys_rst, .raw_sample, .sample_valid, .sample_ready, .filter_mode,
    .avg_log2, .rec_width, .med_width, .filt_out, .filt_valid
);

// >>> sim/msf_sensor_model.sv
// Distance sensor model offering one sample per push
`timescale 1ns/1ps
module msf_sensor_model (
    // Clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         sys_rst,
    // Bench side
    input  wire logic                         push,
    input  wire logic [msf_pkg::SAMPLE_W-1:0] push_data,
    // Filter side
    input  wire logic                         sample_ready,
    output logic      [msf_pkg::SAMPLE_W-1:0] raw_sample,
    output logic                              sample_valid
);
    // Offer held until taken; data inverted after, so stale values never pass
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sample_valid <= 1'b0;
            raw_sample   <= 24'hA5A5A5;
        end else if (push) begin
            sample_valid <= 1'b1;
            raw_sample   <= push_data;
        end else if (sample_valid && sample_ready) begin
            sample_valid <= 1'b0;
            raw_sample   <= ~raw_sample;
        end
    end
endmodule // msf_sensor_model

// >>> sim/tb.sv
// Self-checking bench for the measurement smoothing filter
`timescale 1ns/1ps
module tb;
    import msf_pkg::*;
    typedef struct packed {
        logic [1:0]           mode;
        logic [3:0]           alog;
        logic [REC_N_W-1:0]   rw;
        logic [MED_CNT_W-1:0] mw;
        logic [SAMPLE_W-1:0]  smp;
        logic [SAMPLE_W-1:0]  exp;
    } msf_row_type;
    // Config runs build up history; each config change starts afresh
    localparam msf_row_type ROWS [34] = '{
        '{2'h0, 4'h0, 15'h0000, 4'h3, 24'h000123, 24'h000123},
        '{2'h1, 4'h2, 15'h0000, 4'h3, 24'h000004, 24'h000001},
        '{2'h1, 4'h2, 15'h0000, 4'h3, 24'h000008, 24'h000003},
        '{2'h1, 4'h2, 15'h0000, 4'h3, 24'h00000C, 24'h000006},
        '{2'h1, 4'h2, 15'h0000, 4'h3, 24'h000010, 24'h00000A},
        '{2'h1, 4'h2, 15'h0000, 4'h3, 24'h000014, 24'h00000E},
        '{2'h1, 4'hF, 15'h0000, 4'h3, 24'h010000, 24'h000010},
        '{2'h1, 4'h1, 15'h0000, 4'h3, 24'hFFFFFD, 24'hFFFFFE},
        '{2'h2, 4'h0, 15'h0004, 4'h3, 24'h000064, 24'h000064},
        '{2'h2, 4'h0, 15'h0004, 4'h3, 24'h000000, 24'h00004B},
        '{2'h2, 4'h0, 15'h0004, 4'h3, 24'h000000, 24'h000038},
        '{2'h3, 4'h0, 15'h0000, 4'h5, 24'h000002, 24'h000002},
        '{2'h3, 4'h0, 15'h0000, 4'h5, 24'h000004, 24'h000002},
        '{2'h3, 4'h0, 15'h0000, 4'h5, 24'h000005, 24'h000004},
        '{2'h3, 4'h0, 15'h0000, 4'h5, 24'h000001, 24'h000002},
        '{2'h3, 4'h0, 15'h0000, 4'h5, 24'h000003, 24'h000003},
        '{2'h3, 4'h0, 15'h0000, 4'h5, 24'h000005, 24'h000004},
        '{2'h3, 4'h0, 15'h0000, 4'h3, 24'h000009, 24'h000009},
        '{2'h3, 4'h0, 15'h0000, 4'h3, 24'h000001, 24'h000001},
        '{2'h3, 4'h0, 15'h0000, 4'h3, 24'h000005, 24'h000005},
        '{2'h3, 4'h0, 15'h0000, 4'h3, 24'h000007, 24'h000005},
        '{2'h3, 4'h0, 15'h0000, 4'h7, 24'hFFFFFD, 24'hFFFFFD},
        '{2'h3, 4'h0, 15'h0000, 4'h9, 24'h000006, 24'h000006},
        // Unsupported median width behaves as width 3
        '{2'h3, 4'h0, 15'h0000, 4'hF, 24'h000008, 24'h000008},
        '{2'h3, 4'h0, 15'h0000, 4'hF, 24'h000002, 24'h000002},
        '{2'h3, 4'h0, 15'h0000, 4'hF, 24'h000006, 24'h000006},
        '{2'h3, 4'h0, 15'h0000, 4'hF, 24'h000001, 24'h000002},
        // Zero recursive weight acts as one: first sample seeds, then the divider returns the sample
        '{2'h2, 4'h0, 15'h0000, 4'h3, 24'h000050, 24'h000050},
        '{2'h2, 4'h0, 15'h0000, 4'h3, 24'h000031, 24'h000031},
        // Negative recursion truncates toward zero
        '{2'h2, 4'h0, 15'h0002, 4'h3, 24'hFFFFF8, 24'hFFFFF8},
        '{2'h2, 4'h0, 15'h0002, 4'h3, 24'h000000, 24'hFFFFFC},
        '{2'h2, 4'h0, 15'h0002, 4'h3, 24'h000001, 24'hFFFFFF},
        // Window of one sample passes each sample through
        '{2'h1, 4'h0, 15'h0000, 4'h3, 24'hFFFF00, 24'hFFFF00},
        '{2'h1, 4'h0, 15'h0000, 4'h3, 24'h000077, 24'h000077}
    };
    logic                 clk_sys     = 1'b0;
    logic                 sys_rst     = 1'b1;
    logic [1:0]           filter_mode = 2'h0;
    logic [3:0]           avg_log2    = 4'h0;
    logic [REC_N_W-1:0]   rec_width   = 15'h0000;
    logic [MED_CNT_W-1:0] med_width   = 4'h0;
    logic                 push        = 1'b0;
    logic [SAMPLE_W-1:0]  push_data   = 24'h000000;
    logic [SAMPLE_W-1:0]  raw_sample;
    logic                 sample_valid;
    logic                 sample_ready;
    logic [SAMPLE_W-1:0]  filt_out;
    logic                 filt_valid;
    int                   miscompares = 0;
    int                   n_compared  = 0;
    int                   cycles      = 0;
    ////////////////////////////////////////
    always #4 clk_sys = ~clk_sys;
    msf_sensor_model msf_sensor_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .push(push),
        .push_data(push_data), .sample_ready(sample_ready), .raw_sample(raw_sample),
        .sample_valid(sample_valid));
    msf_filter msf_filter_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .raw_sample(raw_sample),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .filter_mode(filter_mode),
        .avg_log2(avg_log2), .rec_width(rec_width), .med_width(med_width),
        .filt_out(filt_out), .filt_valid(filt_valid));
    ////////////////////////////////////////
    task automatic close_out();
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [SAMPLE_W-1:0] seen, input logic [SAMPLE_W-1:0] want);
        n_compared++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    // Config, two idle cycles to absorb it, then one sample and its result
    task automatic run_row(input msf_row_type r);
        int k;
        @(posedge clk_sys);
        filter_mode <= r.mode;
        avg_log2    <= r.alog;
        rec_width   <= r.rw;
        med_width   <= r.mw;
        repeat (2) @(posedge clk_sys);
        push      <= 1'b1;
        push_data <= r.smp;
        @(posedge clk_sys);
        push <= 1'b0;
        k = 0;
        do begin
            @(negedge clk_sys);
            k++;
        end while (filt_valid !== 1'b1 && k < 100);
        if (k >= 100) miscompares++;
        check(filt_out, r.exp);
    endtask
    // Hang guard, well above the longest expected run
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            close_out();
        end
    end
    ////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        foreach (ROWS[i]) run_row(ROWS[i]);
        // Mid-run reset must drop the window history
        run_row('{MODE_SLIDE, 4'h2, 15'h0000, 4'h3, 24'h000028, 24'h00000A});
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
        check(filt_out, 24'h000000);
        run_row('{MODE_SLIDE, 4'h2, 15'h0000, 4'h3, 24'h000008, 24'h000002});
        close_out();
    end
endmodule // tb
